// [src/icm_defines.svh]
// Register offsets, field positions, reset values and widths for the
// interpolating complex modulator. Assumes byte-wide register port.
//
// Notes on behaviour
// - Dual mode: port A carries I, port B carries Q, taken as one sample.
// - Complex stream times carrier at F/2, F/4 or F/8 of output rate.
// - Interleave bit (reg 2 bit 6): port A alone carries I, Q, I, Q.
// - Interleaved: I and Q paths run at half the port sample rate.
// - Real bit (reg 2 bit 5): Q and modulation off, I is interpolated A.
// - Filter mode from reg 1 bits 5:2, factor from bits 7:6.
// - 8x: even codes DC..-F/8 in eighths; odd code shifts preceding even.
// - 4x: codes 0..7 are DC, F/4, F/2, -F/4, each then shifted.
// - 2x: codes 0..3 are DC, shifted DC, F/2, shifted F/2.
// - Shifted modes move the passband only, never translate the signal.
// - Shifted passbands centre at odd multiples of half the data rate.
// - Factors one (filters bypassed unless interleaved), two, four and eight are supported.
`ifndef ICM_DEFINES_SVH
`define ICM_DEFINES_SVH

`define ICM_OFF_INTERP   8'h01
`define ICM_OFF_CTRL     8'h02
`define ICM_OFF_STATUS   8'h03

`define ICM_FACTOR_MSB   7
`define ICM_FACTOR_LSB   6
`define ICM_MODE_MSB     5
`define ICM_MODE_LSB     2
`define ICM_INTLV_BIT    6
`define ICM_REAL_BIT     5

`define ICM_INTERP_RST   8'h00
`define ICM_CTRL_RST     8'h00

`define ICM_MAX_CODE_2X  4'h3
`define ICM_MAX_CODE_4X  4'h7
`define ICM_MAX_CODE_1X  4'h0

// Status layout: bit 0 reserved code, bit 1 Q pending, bits 7:3 phase
`define ICM_STAT_RSV_BIT 0
`define ICM_STAT_QP_BIT  1
`define ICM_STAT_PH_LSB  3

// Half turn of the 32-step carrier phase, equal to half the data rate
// when divided by the effective interpolation
`define ICM_HALF_TURN    5'h10

`endif

// [src/icm_pkg.sv]
// Types shared by the interpolating complex modulator.
// Self-contained: takes no constants from icm_defines.svh.
package icm_pkg;

    typedef enum logic [1:0] {
        ICM_X1 = 2'h0,
        ICM_X2 = 2'h1,
        ICM_X4 = 2'h2,
        ICM_X8 = 2'h3
    } icm_factor_type;

    typedef logic signed [15:0] icm_sample_type;
    typedef logic signed [16:0] icm_wide_type;
    typedef logic        [4:0]  icm_phase_type;

endpackage

// [src/icm_interp_mod.sv]
// Interpolator with coarse complex modulator, one output sample per mclk.
// Assumes a host that updates its ports right after each dataTake edge.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "icm_defines.svh"

module icm_interp_mod
    import icm_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // Sample ports
    input  wire logic [15:0] portA,
    input  wire logic [15:0] portB,
    output logic             dataTake,
    // Converter sample outputs
    output logic      [15:0] dacI,
    output logic      [15:0] dacQ
);

    // Quarter-wave cosine, Q15, at steps of a 32nd of a turn
    function automatic icm_wide_type cosQuarter(input logic [3:0] k);
        icm_wide_type v;
        v = 17'sh00000;
        case (k)
            4'h0: v = 17'sh07FFF;
            4'h1: v = 17'sh07D8A;
            4'h2: v = 17'sh07642;
            4'h3: v = 17'sh06A6E;
            4'h4: v = 17'sh05A82;
            4'h5: v = 17'sh0471D;
            4'h6: v = 17'sh030FC;
            4'h7: v = 17'sh018F9;
            default: v = 17'sh00000;
        endcase
        return v;
    endfunction

    function automatic icm_wide_type cosTurn(input icm_phase_type p);
        logic [3:0] r;
        logic [3:0] rr;
        icm_wide_type v;
        r  = {1'b0, p[2:0]};
        rr = 4'h8 - r;
        v  = 17'sh00000;
        case (p[4:3])
            2'h0: v = cosQuarter(r);
            2'h1: v = -cosQuarter(rr);
            2'h2: v = -cosQuarter(r);
            default: v = cosQuarter(rr);
        endcase
        return v;
    endfunction

    // Linear interpolation between two held samples
    function automatic icm_wide_type lerp(input icm_wide_type a,
                                          input icm_wide_type b,
                                          input logic [3:0]   ph,
                                          input logic [2:0]   lg);
        logic signed [17:0] d;
        logic signed [22:0] p;
        logic signed [22:0] s;
        d = 18'(b) - 18'(a);
        p = 23'(d) * $signed({19'h00000, ph});
        s = 23'(a) + (p >>> lg);
        return s[16:0];
    endfunction

    function automatic logic [15:0] sat16(input logic signed [34:0] v);
        logic [15:0] r;
        if (v > 35'sh000007FFF) begin
            r = 16'h7FFF;
        end else if (v < -35'sh000008000) begin
            r = 16'h8000;
        end else begin
            r = v[15:0];
        end
        return r;
    endfunction

    // Registers
    logic [7:0]     interpReg;
    logic [7:0]     ctrlReg;
    logic [7:0]     rdataReg;
    logic [2:0]     portCntReg;
    logic           takeReg;
    logic           qPendReg;
    logic           flipReg;
    icm_wide_type   heldIReg;
    icm_wide_type   prevIReg;
    icm_wide_type   prevQReg;
    icm_wide_type   curIReg;
    icm_wide_type   curQReg;
    logic [3:0]     phReg;
    icm_phase_type  phaseReg;
    icm_wide_type   lineIReg;
    icm_wide_type   lineQReg;
    icm_phase_type  linePhReg;
    logic [15:0]    dacIReg;
    logic [15:0]    dacQReg;

    // Configuration decode
    icm_factor_type factor;
    logic [3:0]     modeCode;
    logic           interleave;
    logic           realMode;
    logic [2:0]     lgN;
    logic [2:0]     lgM;
    logic [2:0]     portLast;
    logic [3:0]     phLast;
    logic           reserved;
    logic [2:0]     carrier;
    logic           shifted;
    icm_phase_type  carrierStep;
    icm_phase_type  shiftStep;
    icm_phase_type  phaseStep;

    assign factor     = icm_factor_type'(
                        interpReg[`ICM_FACTOR_MSB:`ICM_FACTOR_LSB]);
    assign modeCode   = interpReg[`ICM_MODE_MSB:`ICM_MODE_LSB];
    assign interleave = ctrlReg[`ICM_INTLV_BIT];
    assign realMode   = ctrlReg[`ICM_REAL_BIT];

    // Port period is N cycles; a complex pair spans 2N when interleaved
    assign lgN      = {1'b0, factor};
    assign lgM      = lgN + {2'h0, interleave};
    assign portLast = 3'((4'h1 << lgN) - 4'h1);
    assign phLast   = 4'((5'h01 << lgM) - 5'h01);

    // Reserved codes fall back to DC, nonshifted
    assign reserved = (factor == ICM_X1 && modeCode > `ICM_MAX_CODE_1X)
                    || (factor == ICM_X2 && modeCode > `ICM_MAX_CODE_2X)
                    || (factor == ICM_X4
                        && modeCode > `ICM_MAX_CODE_4X);

    // Carrier in eighths of the output rate
    always_comb begin
        carrier = 3'h0;
        shifted = 1'b0;
        if (!reserved && !realMode) begin
            unique case (factor)
                ICM_X8: begin
                    carrier = modeCode[3:1];
                    shifted = modeCode[0];
                end
                ICM_X4: begin
                    carrier = {modeCode[2:1], 1'b0};
                    shifted = modeCode[0];
                end
                ICM_X2: begin
                    carrier = {modeCode[1], 2'h0};
                    shifted = modeCode[0];
                end
                ICM_X1: begin
                    carrier = 3'h0;
                    shifted = 1'b0;
                end
            endcase
        end
    end

    // Shifted passband: inputs alternate in sign, which moves the hold
    // kernel by half the data rate, and the output rotation at the same
    // rate puts the signal back where it was
    assign carrierStep = {carrier, 2'h0};
    assign shiftStep   = shifted ? (`ICM_HALF_TURN >> lgM)
                                 : 5'h00;
    assign phaseStep   = carrierStep + shiftStep;

    // Port timing
    logic           portWrap;
    logic [2:0]     portCntNext;
    logic           takeNext;
    logic           pairDone;
    icm_wide_type   inA;
    icm_wide_type   inB;
    icm_wide_type   newI;
    icm_wide_type   newQ;

    assign portWrap    = portCntReg >= portLast;
    assign portCntNext = portWrap ? 3'h0 : portCntReg + 3'h1;
    assign takeNext    = portCntNext == 3'h0;
    assign pairDone    = takeReg && (!interleave || qPendReg);

    assign inA  = {portA[15], portA};
    assign inB  = {portB[15], portB};
    assign newI = interleave ? heldIReg : inA;
    assign newQ = realMode ? 17'sh00000
                : (interleave ? inA : inB);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            portCntReg <= 3'h0;
            takeReg    <= 1'b1;
            qPendReg   <= 1'b0;
            heldIReg   <= 17'sh00000;
        end else begin
            portCntReg <= portCntNext;
            takeReg    <= takeNext;
            if (takeReg && interleave) begin
                qPendReg <= !qPendReg;
            end else if (!interleave) begin
                qPendReg <= 1'b0;
            end
            if (takeReg && interleave && !qPendReg) begin
                heldIReg <= inA;
            end
        end
    end

    // Sample history for interpolation
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flipReg  <= 1'b0;
            prevIReg <= 17'sh00000;
            prevQReg <= 17'sh00000;
            curIReg  <= 17'sh00000;
            curQReg  <= 17'sh00000;
            phReg    <= 4'h0;
        end else if (pairDone) begin
            flipReg  <= !flipReg;
            prevIReg <= curIReg;
            prevQReg <= curQReg;
            curIReg  <= (shifted && flipReg) ? -newI : newI;
            curQReg  <= (shifted && flipReg) ? -newQ : newQ;
            phReg    <= 4'h0;
        end else if (phReg < phLast) begin
            phReg <= phReg + 4'h1;
        end
    end

    // Interpolated stream, one value per output cycle
    icm_wide_type   lineI;
    icm_wide_type   lineQ;

    assign lineI = lerp(prevIReg, curIReg, phReg, lgM);
    assign lineQ = lerp(prevQReg, curQReg, phReg, lgM);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lineIReg  <= 17'sh00000;
            lineQReg  <= 17'sh00000;
            linePhReg <= 5'h00;
            phaseReg  <= 5'h00;
        end else begin
            lineIReg  <= lineI;
            lineQReg  <= lineQ;
            linePhReg <= phaseReg;
            phaseReg  <= phaseReg + phaseStep;
        end
    end

    // Complex multiply by the carrier; sine is cosine a quarter back
    icm_wide_type        carCos;
    icm_wide_type        carSin;
    logic signed [34:0]  mulI;
    logic signed [34:0]  mulQ;
    logic [15:0]         dacINext;
    logic [15:0]         dacQNext;

    assign carCos = cosTurn(linePhReg);
    assign carSin = cosTurn(linePhReg - 5'h08);
    assign mulI = (35'(lineIReg) * 35'(carCos)
                 - 35'(lineQReg) * 35'(carSin)) >>> 15;
    assign mulQ = (35'(lineIReg) * 35'(carSin)
                 + 35'(lineQReg) * 35'(carCos)) >>> 15;

    // Real mode skips the multiplier so the I path keeps unity gain
    assign dacINext = realMode ? sat16(35'(lineIReg)) : sat16(mulI);
    assign dacQNext = realMode ? 16'h0000 : sat16(mulQ);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dacIReg <= 16'h0000;
            dacQReg <= 16'h0000;
        end else begin
            dacIReg <= dacINext;
            dacQReg <= dacQNext;
        end
    end

    // Register port
    logic   selInterp;
    logic   selCtrl;
    logic   selStatus;
    logic [7:0] statusWord;
    logic [7:0] rdataNext;

    assign selInterp = regAddr == `ICM_OFF_INTERP;
    assign selCtrl   = regAddr == `ICM_OFF_CTRL;
    assign selStatus = regAddr == `ICM_OFF_STATUS;

    assign statusWord = ({7'h00, reserved} << `ICM_STAT_RSV_BIT)
                      | ({7'h00, qPendReg} << `ICM_STAT_QP_BIT)
                      | ({3'h0, phaseReg} << `ICM_STAT_PH_LSB);

    assign rdataNext = !regRd    ? 8'h00
                     : selInterp ? interpReg
                     : selCtrl   ? ctrlReg
                     : selStatus ? statusWord
                     : 8'h00;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            interpReg <= `ICM_INTERP_RST;
            ctrlReg   <= `ICM_CTRL_RST;
            rdataReg  <= 8'h00;
        end else begin
            if (regWr && selInterp) begin
                interpReg <= regWdata;
            end
            if (regWr && selCtrl) begin
                ctrlReg <= regWdata;
            end
            rdataReg <= rdataNext;
        end
    end

    assign regRdata = rdataReg;
    assign dataTake = takeReg;
    assign dacI     = dacIReg;
    assign dacQ     = dacQReg;

endmodule

// [verification/icm_interp_monitor.sv]
// Checker: read-back, take cadence, real mode, reserved mode codes.
// Assumes binding to icm_interp_mod; shadows registers from writes.
`timescale 1ns/1ps
module icm_interp_monitor (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdata,
    // Sample side
    input wire logic        dataTake,
    input wire logic [15:0] dacQ
);
    logic [7:0] interp_reg;
    logic [7:0] ctrl_reg;
    logic [3:0] gap_reg;
    logic [4:0] age_reg;
    wire  [1:0] factor = interp_reg[7:6];
    wire  [3:0] mode   = interp_reg[5:2];
    wire        rsvExp = (factor == 2'h0) ? (mode != 4'h0) :
                         (factor == 2'h1) ? (mode > 4'h3) :
                         (factor == 2'h2) ? (mode > 4'h7) : 1'b0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            interp_reg <= 8'h00;
            ctrl_reg   <= 8'h00;
            gap_reg    <= 4'h0;
            age_reg    <= 5'h00;
        end else begin
            if (regWr && regAddr == 8'h01)
                interp_reg <= regWdata;
            if (regWr && regAddr == 8'h02)
                ctrl_reg <= regWdata;
            gap_reg <= dataTake ? 4'h1 : gap_reg + 4'h1;
            // Saturates so old configs count as settled
            age_reg <= regWr ? 5'h00 : age_reg + {4'h0, ~&age_reg};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_rdata_idle: assert property (
        !regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside reply");
    a_interp_read: assert property (
        regRd && regAddr == 8'h01 |=> regRdata == $past(interp_reg))
        else $error("factor and mode read-back wrong");
    a_ctrl_read: assert property (
        regRd && regAddr == 8'h02 |=> regRdata[6:5] == $past(ctrl_reg[6:5]))
        else $error("control read-back wrong");
    a_unmapped_read: assert property (
        regRd && (regAddr == 8'h00 || regAddr > 8'h03) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_take_gap: assert property (
        dataTake && age_reg > 5'h0F |-> gap_reg == (4'h1 << factor))
        else $error("take spacing differs from factor");
    a_take_single: assert property (
        dataTake && factor != 2'h0 && age_reg > 5'h0F |=> !dataTake)
        else $error("take longer than one cycle");
    a_real_qzero: assert property (
        ctrl_reg[5] && age_reg > 5'h07 |-> dacQ == 16'h0000)
        else $error("Q output active in real mode");
    a_rsv_flag: assert property (
        regRd && regAddr == 8'h03 |=> regRdata[0] == $past(rsvExp))
        else $error("reserved code flag wrong");

    c_rsv_read: cover property (regRd && regAddr == 8'h03 && rsvExp);
    c_real_run: cover property (ctrl_reg[5] && dataTake);
    c_eight_take: cover property (dataTake && factor == 2'h3);
endmodule

bind icm_interp_mod icm_interp_monitor mon (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .dataTake(dataTake), .dacQ(dacQ));

// [verification/icm_host_model.sv]
// Host model: feeds the sample ports, advancing at each take.
// Assumes the bench raises intlv together with the interleave write.
`timescale 1ns/1ps
module icm_host_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Bench control
    input  wire logic        intlv,
    input  wire logic [15:0] iVal,
    input  wire logic [15:0] qVal,
    // Device side
    input  wire logic        dataTake,
    output logic      [15:0] portA,
    output logic      [15:0] portB
);
    logic qNext;
    logic armed;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            qNext <= 1'b0;
            armed <= 1'b0;
            portA <= 16'h0000;
            portB <= 16'h0000;
        end else begin
            // Fresh interleave restarts at I, as the device does
            armed <= intlv;
            if (dataTake) begin
                qNext <= intlv & armed & ~qNext;
                portA <= (intlv & armed & ~qNext)
                         ? qVal : iVal;
                // Unused port never holds a stale value
                portB <= intlv ? ~portB : qVal;
            end
        end
    end
endmodule

// [verification/icm_tb.sv]
// Bench: register tasks, modulation table, interleave, real mode.
// Assumes design, host model and checker compiled first.
`timescale 1ns/1ps
module tb;
    logic        mclk, nrst, regWr, regRd, intlv, dataTake;
    logic        rdLag = 1'b0;
    logic [7:0]  regAddr, regWdata, regRdata, cfg;
    logic [15:0] portA, portB, iVal, qVal, dacI, dacQ, pI, pQ, ei, eq;
    logic [7:0]  expQ[$];
    logic [7:0]  mskQ[$];
    int          num_errors, cmp_count, seed, n, t;
    logic [7:0]  modTbl [8] = '{8'h00, 8'h49, 8'h8A, 8'h91, 8'h9B, 8'hD2,
                                8'hE1, 8'hF3};
    logic [6:0]  rsvTbl [7] = '{7'h00, 7'h03, 7'h26, 7'h29, 7'h4E, 7'h51,
                                7'h7E};

    icm_interp_mod uut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .portA(portA), .portB(portB),
        .dataTake(dataTake), .dacI(dacI), .dacQ(dacQ));
    icm_host_model host (.mclk(mclk), .nrst(nrst), .intlv(intlv),
        .iVal(iVal), .qVal(qVal), .dataTake(dataTake), .portA(portA),
        .portB(portB));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic bad(input string m);
        num_errors++;
        $display("BAD t=%0t %s", $time, m);
    endtask
    task automatic chk_reg(input logic [7:0] got, exp, msk);
        cmp_count++;
        if ((got & msk) !== (exp & msk))
            bad($sformatf("reg %h exp %h", got, exp));
    endtask
    task automatic chk_near(input logic [15:0] got, exp, input int tol);
        int d;
        d = int'($signed(got)) - int'($signed(exp));
        cmp_count++;
        if ($isunknown(got) || d > tol || d < -tol)
            bad($sformatf("dac %h exp %h", got, exp));
    endtask
    // Strobes set each call, so back-to-back calls never double-assign
    task automatic bus(input logic w, r, input logic [7:0] a, d);
        regWr    <= w;
        regRd    <= r;
        regAddr  <= a;
        regWdata <= d;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, e, m);
        expQ.push_back(e);
        mskQ.push_back(m);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic take_gap(input logic [7:0] e);
        int k;
        int last;
        logic [7:0] gap;
        last = 0;
        gap = 8'h00;
        for (k = 1; k <= 20; k++) begin
            @(negedge mclk);
            if (dataTake === 1'b1) begin
                gap = 8'(k - last);
                last = k;
            end
        end
        chk_reg(gap, e, 8'hFF);
        @(posedge mclk);
    endtask

    always @(posedge mclk) rdLag <= regRd;
    always @(negedge mclk) begin
        if (rdLag === 1'b1) begin
            if (expQ.size() == 0)
                bad("read reply with no expectation");
            else
                chk_reg(regRdata, expQ.pop_front(), mskQ.pop_front());
        end
    end

    initial begin
        seed = 93123;
        nrst = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        intlv = 1'b0;
        iVal = 16'h0000;
        qVal = 16'h0000;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(8'h01, 8'h00, 8'hFF);
        rd(8'h02, 8'h00, 8'hFF);
        bus(1'b1, 1'b0, 8'h07, 8'hA5);
        rd(8'h07, 8'h00, 8'hFF);
        bus(1'b1, 1'b0, 8'h01, 8'hC0);
        rd(8'h01, 8'hC0, 8'hFF);
        $display("test registers done");
        // Carrier phase still zero, so the first entry is absolute
        for (n = 0; n < 8; n++) begin
            cfg = modTbl[n];
            iVal <= 16'($random(seed) >>> 19);
            qVal <= 16'($random(seed) >>> 19);
            bus(1'b1, 1'b0, 8'h01, {cfg[7:2], 2'b00});
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (40) @(posedge mclk);
            @(negedge mclk);
            pI = dacI;
            pQ = dacQ;
            @(negedge mclk);
            ei = (cfg[1:0] == 2'h0) ? iVal : (cfg[1:0] == 2'h1) ? -pI :
                 (cfg[1:0] == 2'h2) ? -pQ : pQ;
            eq = (cfg[1:0] == 2'h0) ? qVal : (cfg[1:0] == 2'h1) ? -pQ :
                 (cfg[1:0] == 2'h2) ? pI : -pI;
            chk_near(dacI, ei, 4);
            chk_near(dacQ, eq, 4);
            @(posedge mclk);
        end
        // Eighth-turn carrier at 8x: cosine of 45 degrees in Q15
        bus(1'b1, 1'b0, 8'h01, 8'hC8);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (40) @(posedge mclk);
        @(negedge mclk);
        pI = dacI;
        pQ = dacQ;
        @(negedge mclk);
        t = (int'($signed(pI)) - int'($signed(pQ))) * 23170;
        ei = 16'(t >>> 15);
        t = (int'($signed(pI)) + int'($signed(pQ))) * 23170;
        eq = 16'(t >>> 15);
        chk_near(dacI, ei, 4);
        chk_near(dacQ, eq, 4);
        @(posedge mclk);
        // Shifted DC at 2x: a translated signal would flip sign each pair
        bus(1'b1, 1'b0, 8'h01, 8'h44);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (40) @(posedge mclk);
        @(negedge mclk);
        pI = dacI;
        pQ = dacQ;
        @(negedge mclk);
        ei = dacI;
        eq = dacQ;
        @(negedge mclk);
        chk_near(dacI, pI, 4);
        chk_near(dacQ, pQ, 4);
        @(negedge mclk);
        chk_near(dacI, ei, 4);
        chk_near(dacQ, eq, 4);
        @(posedge mclk);
        $display("test modulation done");
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        iVal <= 16'($random(seed) >>> 19);
        qVal <= 16'($random(seed) >>> 19);
        @(posedge mclk);
        intlv <= 1'b1;
        bus(1'b1, 1'b0, 8'h02, 8'h40);
        bus(1'b1, 1'b0, 8'h01, 8'h40);
        rd(8'h02, 8'h40, 8'h60);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (60) @(posedge mclk);
        @(negedge mclk);
        chk_near(dacI, iVal, 4);
        chk_near(dacQ, qVal, 4);
        @(posedge mclk);
        take_gap(8'h02);
        $display("test interleave done");
        intlv <= 1'b0;
        iVal <= 16'($random(seed) >>> 19);
        bus(1'b1, 1'b0, 8'h02, 8'h20);
        bus(1'b1, 1'b0, 8'h01, 8'h88);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (40) @(posedge mclk);
        repeat (3) begin
            @(negedge mclk);
            chk_near(dacI, iVal, 0);
            chk_near(dacQ, 16'h0000, 0);
        end
        @(posedge mclk);
        bus(1'b1, 1'b0, 8'h02, 8'h00);
        $display("test real mode done");
        for (n = 0; n < 7; n++) begin
            bus(1'b1, 1'b0, 8'h01, {rsvTbl[n][6:1], 2'b00});
            rd(8'h03, {7'h00, rsvTbl[n][0]}, 8'h01);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (20) @(posedge mclk);
            take_gap(8'h01 << rsvTbl[n][6:5]);
        end
        $display("test codes and factors done");
        test_done();
    end
endmodule
